/* shared/ebm_pkg.sv */
package ebm_pkg;

  // ==========================================================
  // Register offsets, relative to the module base
  localparam logic [9:0] OFF_DRIVE = 10'h00d;
  localparam logic [9:0] OFF_BUSCTL = 10'h00e;
  localparam logic [9:0] OFF_RSVD = 10'h00f;
  localparam logic [9:0] OFF_IRQCTL = 10'h01e;
  localparam logic [9:0] OFF_PKDATA = 10'h032;
  localparam logic [9:0] OFF_PKDIR = 10'h033;

  // ==========================================================
  // Field positions
  localparam int BIT_DRV_K = 7;
  localparam int BIT_DRV_E = 4;
  localparam int BIT_DRV_B = 1;
  localparam int BIT_DRV_A = 0;
  localparam int BIT_STRETCH = 0;
  localparam int BIT_EDGE = 7;
  localparam int BIT_PINEN = 6;
  localparam int BIT_ECS = 7;
  localparam int BIT_XCS = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_IRQCTL = 8'h40;
  localparam logic [7:0] RST_PKDATA = 8'h00;
  localparam logic [7:0] RST_PKDIR = 8'h00;
  localparam logic RST_STRETCH_USER = 1'b1;

  // ==========================================================
  // Operating modes, encoded as the three mode bits
  localparam logic [2:0] MODE_SPC_SINGLE = 3'h0;
  localparam logic [2:0] MODE_EMU_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPC_TEST = 3'h2;
  localparam logic [2:0] MODE_EMU_WIDE = 3'h3;
  localparam logic [2:0] MODE_NRM_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NRM_NARROW = 3'h5;
  localparam logic [2:0] MODE_PERIPHERAL = 3'h6;
  localparam logic [2:0] MODE_NRM_WIDE = 3'h7;

  // Per-port reduced drive selections
  typedef struct packed {
    logic port_k;
    logic port_e;
    logic port_b;
    logic port_a;
  } ebm_drive_s;

  // Page port pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ebm_pins_s;

endpackage

/* src/ebm_regs.sv */
// Operation
// RULE1: Drive bits 7,4,1,0 select reduced drive when set, full when clear.
// RULE2: Drive selection applies whatever function owns the port pins.
// RULE3: Drive, bus-control and reserved slots unmapped outside single-chip.
// RULE4: Stretch bit clear keeps E free-running; set lets E stretch.
// RULE5: Stretch bit writes once in normal/emulation, any time in special.
// RULE6: Stretch bit has no effect in single-chip modes.
// RULE7: Reserved slot reads zero and ignores writes.
// RULE8: Edge select bit 7: clear means low level, set falling edges only.
// RULE9: Edge select readable always; written once unless in special mode.
// RULE10: In edge mode a falling edge is latched until reset or service.
// RULE11: Pin enable bit 6, always read/write, connects the interrupt pin.
// RULE12: Pin enable clear holds the edge latch disabled.
// RULE13: Direction set makes a page pin an output, clear a floating input.
// RULE14: Data read returns pin level for inputs, latch for outputs.
// RULE15: Page data unmapped in expanded/peripheral modes with emulation bit.
// RULE16: Page input pins float or pull up per the pull-enable bit.
// RULE17: Page bit 7 is emulation chip select or I/O per emulation bit.
// RULE18: Page bit 6 is external chip select or I/O per emulation bit.
// RULE19: Chip selects deassert after E falls, except stretched free-run E.
// RULE20: Page bits 5:0 drive expanded address bits 19 to 14 unless I/O.
// RULE21: All registers decode at fixed offsets from a relocatable base.
// RULE22: Reset sets the stretch bit in every user mode.
// RULE23: Page data/direction leave map with emulation bit when expanded.
// RULE24: Registers are eight bits; unimplemented bits read zero.
`timescale 1ns/10ps
`default_nettype none

module ebm_regs
  import ebm_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  // Module base and mode
  input  wire logic [15:0] MAP_BASE,
  input  wire logic [2:0]  MODE,
  input  wire logic        PORT_EMULATION_BIT,
  input  wire logic        PAGE_PORT_PULL_ENABLE,
  // External memory cycle state
  input  wire logic        BUS_E_CLOCK,
  input  wire logic        EXT_STRETCH,
  input  wire logic        EMU_CS_REQ,
  input  wire logic        EXT_CS_REQ,
  input  wire logic [5:0]  PAGE_NUMBER,
  // External interrupt
  input  wire logic        IRQ_PIN_N,
  input  wire logic        IRQ_SERVICED,
  output logic             IRQ_REQUEST,
  // Control outputs
  output ebm_drive_s       DRIVE_REDUCED,
  output logic             STRETCH_ACTIVE,
  output logic             EXT_ECHO,
  // Page port pins
  input  wire logic [7:0]  PAGE_PIN_IN,
  output ebm_pins_s        PAGE_PINS,
  output logic      [7:0]  PAGE_PULLUP
);

  // ==========================================================
  // Mode classification
  logic single_chip;
  logic special_mode;
  logic user_mode;
  logic page_emulated;
  assign single_chip = (MODE == MODE_SPC_SINGLE) || (MODE == MODE_NRM_SINGLE);
  assign special_mode = (MODE == MODE_SPC_SINGLE) || (MODE == MODE_SPC_TEST)
                     || (MODE == MODE_PERIPHERAL);
  assign user_mode = (MODE != MODE_SPC_SINGLE) && (MODE != MODE_SPC_TEST)
                  && (MODE != MODE_PERIPHERAL);
  assign page_emulated = PORT_EMULATION_BIT && !single_chip; // RULE15 RULE23

  // ==========================================================
  // Address decode relative to relocatable base
  logic [15:0] rel_addr;
  logic        in_window;
  logic [9:0]  offs;
  assign rel_addr = PADDR - MAP_BASE; // RULE21
  assign in_window = (rel_addr[15:10] == 6'h00) && (rel_addr[1:0] == 2'h0);
  assign offs = rel_addr[11:2];

  logic hit_drive;
  logic hit_busctl;
  logic hit_rsvd;
  logic hit_irq;
  logic hit_pkdata;
  logic hit_pkdir;
  logic core_mapped;
  assign core_mapped = single_chip; // RULE3
  assign hit_drive = in_window && offs == OFF_DRIVE && core_mapped;
  assign hit_busctl = in_window && offs == OFF_BUSCTL && core_mapped;
  assign hit_rsvd = in_window && offs == OFF_RSVD && core_mapped; // RULE7
  assign hit_irq = in_window && offs == OFF_IRQCTL;
  assign hit_pkdata = in_window && offs == OFF_PKDATA && !page_emulated;
  assign hit_pkdir = in_window && offs == OFF_PKDIR && !page_emulated;

  logic hit_any;
  logic wr_en;
  assign hit_any = hit_drive || hit_busctl || hit_rsvd || hit_irq
                || hit_pkdata || hit_pkdir;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign EXT_ECHO = PSEL && in_window && !hit_any;

  // ==========================================================
  // Input synchronisers
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic       irq_s1;
  logic       irq_s2;
  logic       irq_prev;
  always_ff @(posedge CLK) begin
    pin_s1 <= PAGE_PIN_IN;
    pin_s2 <= pin_s1;
    irq_s1 <= IRQ_PIN_N;
    irq_s2 <= irq_s1;
    irq_prev <= irq_s2;
  end

  // ==========================================================
  // Register storage
  logic [3:0] drive;
  logic       stretch;
  logic       stretch_wrote;
  logic       edge_sel;
  logic       edge_wrote;
  logic       pin_en;
  logic [7:0] pk_data;
  logic [7:0] pk_dir;
  logic       edge_latch;

  always_ff @(posedge CLK) begin
    if (RST) begin
      drive <= {RST_DRIVE[BIT_DRV_K], RST_DRIVE[BIT_DRV_E],
                RST_DRIVE[BIT_DRV_B], RST_DRIVE[BIT_DRV_A]};
    end else if (wr_en && hit_drive) begin
      drive <= {PWDATA[BIT_DRV_K], PWDATA[BIT_DRV_E],
                PWDATA[BIT_DRV_B], PWDATA[BIT_DRV_A]}; // RULE1 RULE24
    end
  end

  // Mode is caught on the first cycle after reset release
  logic rst_seen;
  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_seen <= 1'b1;
    end else begin
      rst_seen <= 1'b0;
    end
  end

  logic busctl_wr;
  assign busctl_wr = wr_en && hit_busctl && (special_mode || !stretch_wrote);
  always_ff @(posedge CLK) begin
    if (RST) begin
      stretch_wrote <= 1'b0;
      stretch <= 1'b0;
    end else begin
      if (busctl_wr) begin
        stretch <= PWDATA[BIT_STRETCH]; // RULE5
        stretch_wrote <= 1'b1;
      end else if (!stretch_wrote && rst_seen) begin
        stretch <= user_mode ? RST_STRETCH_USER : 1'b0; // RULE22
      end
    end
  end

  logic irq_wr;
  assign irq_wr = wr_en && hit_irq;
  always_ff @(posedge CLK) begin
    if (RST) begin
      edge_sel <= RST_IRQCTL[BIT_EDGE];
      edge_wrote <= 1'b0;
      pin_en <= RST_IRQCTL[BIT_PINEN];
    end else if (irq_wr) begin
      pin_en <= PWDATA[BIT_PINEN]; // RULE11
      if (special_mode || !edge_wrote) begin
        edge_sel <= PWDATA[BIT_EDGE]; // RULE9
        edge_wrote <= 1'b1;
      end
    end
  end

  // Falling-edge latch; a new edge wins over service
  logic fall_seen;
  assign fall_seen = irq_prev && !irq_s2;
  always_ff @(posedge CLK) begin
    if (RST || !pin_en || !edge_sel) begin
      edge_latch <= 1'b0; // RULE12
    end else if (fall_seen) begin
      edge_latch <= 1'b1; // RULE10
    end else if (IRQ_SERVICED) begin
      edge_latch <= 1'b0; // RULE10
    end
  end
  assign IRQ_REQUEST = pin_en && (edge_sel ? edge_latch : !irq_s2); // RULE8

  always_ff @(posedge CLK) begin
    if (RST) begin
      pk_data <= RST_PKDATA;
      pk_dir <= RST_PKDIR;
    end else begin
      if (wr_en && hit_pkdata) begin
        pk_data <= PWDATA[7:0];
      end
      if (wr_en && hit_pkdir) begin
        pk_dir <= PWDATA[7:0];
      end
    end
  end

  // ==========================================================
  // Read mux
  logic [7:0] drive_rd;
  logic [7:0] busctl_rd;
  logic [7:0] irq_rd;
  logic [7:0] pk_rd;
  logic [7:0] rd_byte;
  always_comb begin
    drive_rd = 8'h00;
    drive_rd[BIT_DRV_K] = drive[3];
    drive_rd[BIT_DRV_E] = drive[2];
    drive_rd[BIT_DRV_B] = drive[1];
    drive_rd[BIT_DRV_A] = drive[0];
    busctl_rd = 8'h00;
    busctl_rd[BIT_STRETCH] = stretch;
    irq_rd = 8'h00;
    irq_rd[BIT_EDGE] = edge_sel;
    irq_rd[BIT_PINEN] = pin_en;
  end
  assign pk_rd = (pk_dir & pk_data) | (~pk_dir & pin_s2); // RULE14
  assign rd_byte = hit_drive  ? drive_rd :
                   hit_busctl ? busctl_rd :
                   hit_irq    ? irq_rd :
                   hit_pkdata ? pk_rd :
                   hit_pkdir  ? pk_dir : 8'h00; // RULE7 RULE24

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // Control outputs
  assign DRIVE_REDUCED = {drive[3], drive[2], drive[1], drive[0]}; // RULE2
  assign STRETCH_ACTIVE = stretch && !single_chip; // RULE4 RULE6

  // ==========================================================
  // Page port pins
  logic e_prev;
  logic cs_gap;
  always_ff @(posedge CLK) begin
    if (RST) begin
      e_prev <= 1'b0;
    end else begin
      e_prev <= BUS_E_CLOCK;
    end
  end
  // One cycle deassert after E falls, skipped for stretched free-run
  assign cs_gap = e_prev && !BUS_E_CLOCK
               && !(EXT_STRETCH && !stretch); // RULE19

  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end else if (page_emulated) begin
      pin_out[BIT_ECS] <= !(EMU_CS_REQ && !cs_gap); // RULE17 RULE19
      pin_out[BIT_XCS] <= !(EXT_CS_REQ && !EMU_CS_REQ && !cs_gap); // RULE18
      pin_out[5:0] <= PAGE_NUMBER; // RULE20
      pin_oe <= 8'hff;
    end else begin
      pin_out <= pk_data;
      pin_oe <= pk_dir; // RULE13
    end
  end
  assign PAGE_PINS = '{out: pin_out, oe: pin_oe};
  assign PAGE_PULLUP = PAGE_PORT_PULL_ENABLE ? ~pin_oe : 8'h00; // RULE16

  // ==========================================================
  // Checks
  a_rsvd_reads_zero: // RULE7
    assert property (@(posedge CLK) disable iff (RST)
      (PSEL && !PENABLE && !PWRITE && hit_rsvd) |=> PRDATA == 32'h0)
    else $error("reserved slot read nonzero");
  a_edge_latch_off: // RULE12
    assert property (@(posedge CLK) disable iff (RST)
      !pin_en |=> !edge_latch)
    else $error("edge latch active while pin disabled");
  a_stretch_once: // RULE5
    assert property (@(posedge CLK) disable iff (RST)
      (!special_mode && stretch_wrote && !rst_seen) |=> $stable(stretch))
    else $error("stretch bit changed after its single write");
  a_edge_once: // RULE9
    assert property (@(posedge CLK) disable iff (RST)
      (!special_mode && edge_wrote) |=> $stable(edge_sel))
    else $error("edge select changed after its single write");
  a_single_no_stretch: // RULE6
    assert property (@(posedge CLK) single_chip |-> !STRETCH_ACTIVE)
    else $error("stretch active in single chip mode");
  a_core_unmapped: // RULE3
    assert property (@(posedge CLK) disable iff (RST)
      (!single_chip && PSEL && PENABLE && in_window
       && (offs == OFF_DRIVE || offs == OFF_BUSCTL || offs == OFF_RSVD))
      |-> PSLVERR)
    else $error("core register mapped in expanded mode");
  a_unmapped_read_zero: // RULE24
    assert property (@(posedge CLK) disable iff (RST)
      (PSEL && !PENABLE && !PWRITE && !hit_any) |=> PRDATA == 32'h0)
    else $error("unmapped read returned nonzero");
  a_cs_gap_high: // RULE19
    assert property (@(posedge CLK) disable iff (RST)
      (page_emulated && cs_gap) |=> PAGE_PINS.out[BIT_ECS])
    else $error("emulation chip select low in E gap");
  a_page_dir_pins: // RULE13
    assert property (@(posedge CLK) disable iff (RST)
      (!page_emulated && $stable(pk_dir)) |=> pin_oe == $past(pk_dir))
    else $error("page pin enables differ from direction");
  a_edge_held: // RULE10
    assert property (@(posedge CLK) disable iff (RST)
      (edge_latch && pin_en && edge_sel && !IRQ_SERVICED
       && $stable(pin_en) && !irq_wr) |=> edge_latch)
    else $error("edge latch lost without service");

endmodule

`default_nettype wire

/* testbench/ebm_page_pad.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Page port pads with a memory device on the far side
module ebm_page_pad
  import ebm_pkg::*;
(
  // Clock
  input  wire logic       CLK,
  // Port side
  input  wire ebm_pins_s  PINS,
  input  wire logic [7:0] PULLUP,
  // Far side
  input  wire logic       EXT_DRIVE,
  input  wire logic [7:0] EXT_LEVEL,
  // Resolved pin level
  output logic      [7:0] LEVEL
);
  logic [7:0] wander = 8'h55;
  logic [7:0] idle_lvl;
  // Undriven pins without pull-up never hold a clean value
  always_ff @(posedge CLK) begin
    wander <= ~wander;
  end
  assign idle_lvl = EXT_DRIVE ? EXT_LEVEL : (PULLUP | wander);
  assign LEVEL = (PINS.oe & PINS.out) | (~PINS.oe & idle_lvl);
endmodule
`default_nettype wire

/* testbench/ext_bus_misc_control_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ext_bus_misc_control_regs_tb_top
  import ebm_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = 16'h0000, base = 16'h0400;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  mode = MODE_NRM_SINGLE;
  logic        port_emulation_bit = 1'b0, pue = 1'b1, emcs = 1'b0, irq_n = 1'b1;
  logic        svc = 1'b0, xdrv = 1'b0, pready, perr, err, irq, str;
  logic        bus_e_clock = 1'b1, xstr = 1'b0, xcs = 1'b0, ech, ec;
  logic [7:0]  pin, pull;
  ebm_drive_s  drv;
  ebm_pins_s   pins;
  int          mismatches = 0, compares = 0;

  always #4 clk = ~clk;

  ebm_regs u_ebm_regs (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(perr), .MAP_BASE(base), .MODE(mode),
    .PORT_EMULATION_BIT(port_emulation_bit), .PAGE_PORT_PULL_ENABLE(pue),
    .BUS_E_CLOCK(bus_e_clock), .EXT_STRETCH(xstr), .EMU_CS_REQ(emcs),
    .EXT_CS_REQ(xcs), .PAGE_NUMBER(6'h2a), .IRQ_PIN_N(irq_n),
    .IRQ_SERVICED(svc), .IRQ_REQUEST(irq), .DRIVE_REDUCED(drv),
    .STRETCH_ACTIVE(str), .EXT_ECHO(ech), .PAGE_PIN_IN(pin),
    .PAGE_PINS(pins), .PAGE_PULLUP(pull));

  ebm_page_pad u_ebm_page_pad (
    .CLK(clk), .PINS(pins), .PULLUP(pull), .EXT_DRIVE(xdrv),
    .EXT_LEVEL(8'h30), .LEVEL(pin));

  // ==========================================================
  // Access and check tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] off,
                     input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= base + {4'h0, off, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = perr;
    ec  = ech;
    psel <= 1'b0;
    pen  <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [9:0] off, input logic [7:0] d);
    apb(1'b1, off, d);
  endtask

  task automatic rdc(input logic [9:0] off, input logic [7:0] e,
                     input logic ee);
    apb(1'b0, off, 8'h00);
    chk(rd, {24'h0, e});
    chk({31'h0, err}, {31'h0, ee});
    chk({31'h0, ec}, {31'h0, ee});
  endtask

  task automatic wt;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic rst_to(input logic [2:0] m);
    @(posedge clk);
    mode <= m;
    rst  <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic pulse;
    @(posedge clk);
    irq_n <= 1'b0;
    repeat (3) @(posedge clk);
    irq_n <= 1'b1;
    wt();
  endtask

  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    rst_to(MODE_NRM_SINGLE);
    rdc(OFF_DRIVE, RST_DRIVE, 1'b0);
    rdc(OFF_BUSCTL, 8'h01, 1'b0);
    rdc(OFF_IRQCTL, RST_IRQCTL, 1'b0);
    chk(32'(str), 32'h0);
    wr(OFF_RSVD, 8'hff);
    rdc(OFF_RSVD, 8'h00, 1'b0);
    $display("test reset done");
    wr(OFF_DRIVE, 8'hff);
    rdc(OFF_DRIVE, 8'h93, 1'b0);
    chk(32'(drv), 32'hf);
    wr(OFF_DRIVE, 8'h12);
    chk(32'(drv), 32'h6);
    wr(OFF_BUSCTL, 8'h00);
    wr(OFF_BUSCTL, 8'h01);
    rdc(OFF_BUSCTL, 8'h00, 1'b0);
    $display("test drive and stretch done");
    @(posedge clk);
    mode <= MODE_NRM_WIDE;
    wr(OFF_DRIVE, 8'h00);
    rdc(OFF_DRIVE, 8'h00, 1'b1);
    rdc(OFF_BUSCTL, 8'h00, 1'b1);
    rdc(OFF_RSVD, 8'h00, 1'b1);
    chk(32'(str), 32'h0);
    @(posedge clk);
    port_emulation_bit  <= 1'b1;
    emcs <= 1'b1;
    rdc(OFF_PKDATA, 8'h00, 1'b1);
    rdc(OFF_PKDIR, 8'h00, 1'b1);
    chk(32'(pins.out), 32'h6a);
    @(posedge clk);
    bus_e_clock <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(pins.out[7]), 32'h1);
    @(posedge clk);
    #1;
    chk(32'(pins.out[7]), 32'h0);
    @(posedge clk);
    bus_e_clock <= 1'b1;
    xstr <= 1'b1;
    emcs <= 1'b0;
    xcs  <= 1'b1;
    @(posedge clk);
    bus_e_clock <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(pins.out[7:6]), 32'h2);
    @(posedge clk);
    mode <= MODE_NRM_SINGLE;
    emcs <= 1'b0;
    xcs  <= 1'b0;
    xstr <= 1'b0;
    rdc(OFF_DRIVE, 8'h12, 1'b0);
    rdc(OFF_PKDIR, 8'h00, 1'b0);
    @(posedge clk);
    port_emulation_bit <= 1'b0;
    $display("test map done");
    wr(OFF_PKDATA, 8'ha5);
    wr(OFF_PKDIR, 8'h0f);
    wt();
    chk(32'(pins.oe), 32'h0f);
    chk(32'(pins.out[3:0]), 32'h5);
    chk(32'(pull), 32'hf0);
    rdc(OFF_PKDATA, 8'hf5, 1'b0);
    @(posedge clk);
    xdrv <= 1'b1;
    pue  <= 1'b0;
    wt();
    chk(32'(pull), 32'h00);
    rdc(OFF_PKDATA, 8'h35, 1'b0);
    $display("test page port done");
    wr(OFF_IRQCTL, 8'hc0);
    wr(OFF_IRQCTL, 8'h40);
    rdc(OFF_IRQCTL, 8'hc0, 1'b0);
    pulse();
    chk(32'(irq), 32'h1);
    @(posedge clk);
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    wt();
    chk(32'(irq), 32'h0);
    wr(OFF_IRQCTL, 8'h80);
    rdc(OFF_IRQCTL, 8'h80, 1'b0);
    pulse();
    chk(32'(irq), 32'h0);
    wr(OFF_IRQCTL, 8'hc0);
    wt();
    chk(32'(irq), 32'h0);
    @(posedge clk);
    base <= 16'h0800;
    rdc(OFF_IRQCTL, 8'hc0, 1'b0);
    $display("test interrupt done");
    rst_to(MODE_SPC_SINGLE);
    rdc(OFF_BUSCTL, 8'h00, 1'b0);
    wr(OFF_BUSCTL, 8'h01);
    wr(OFF_BUSCTL, 8'h00);
    rdc(OFF_BUSCTL, 8'h00, 1'b0);
    wr(OFF_IRQCTL, 8'hc0);
    wr(OFF_IRQCTL, 8'h40);
    rdc(OFF_IRQCTL, 8'h40, 1'b0);
    @(posedge clk);
    irq_n <= 1'b0;
    wt();
    chk(32'(irq), 32'h1);
    @(posedge clk);
    irq_n <= 1'b1;
    wt();
    chk(32'(irq), 32'h0);
    rst_to(MODE_NRM_WIDE);
    chk(32'(str), 32'h1);
    $display("test special mode done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
